// [scp_status_parser.sv]
// Command syntax checker and status reporting model of the remote interface.
// Assumes one byte per rx_valid_i cycle and condition inputs synchronous to sys_clk_i.
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - A keyword matches in its short form or its full form alike.
// - Any other spelling is refused and flags a command error.
// - Keywords are joined by colons with no space on either side.
// - Condition bits follow the instrument inputs every cycle, unlatched.
// - Condition bits are read-only and reading does not disturb them.
// - A query answers with the decimal weighted sum of the bits.
// - Event bits latch once; repeats while set change nothing.
// - Event bits stay set until *ESR? or *CLS clears them.
// - Enable masks pass only enabled events into the status byte.
// - Enable registers can be written and read back.
// - *CLS clears events but keeps every enable register.
// - Message available, status bit 3, rises as soon as reply data exist.
// - Clearing an event bit recomputes its summary through the enable mask.
// - Message available clears once the host has read every reply byte.
// - Status byte: bit1 rampdown, bit2 quench, bit3 message, bit5, bit6 summaries.
// - Event bits: 0 complete, 2-5 errors, 7 power on.
module scp_status_parser (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	output logic [7:0] tx_data_o,
	output logic tx_valid_o,
	input wire logic tx_ready_i,
	input wire logic ext_rampdown_i,
	input wire logic quench_i,
	input wire logic dev_err_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	output logic irq_o
);
	import scp_pkg::*;

	scp_tok_if tok ();
	scp_rep_if rep ();

	scp_kw_match u_match (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.tok(tok.match)
	);

	scp_reply u_reply (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.rep(rep.reply),
		.tx_data_o(tx_data_o),
		.tx_valid_o(tx_valid_o),
		.tx_ready_i(tx_ready_i)
	);

	scp_state_t state_q, state_d;
	logic star_q, query_q, has_par_q, pdone_q, over_q;
	logic [3:0] kw_q;
	logic [8:0] par_q;
	logic [7:0] esr_q, ese_q, sre_q;
	logic psc_q;
	logic [2:0] irq_stat_q, irq_en_q;
	logic rqs_q;

	logic c_alpha, c_digit, c_space, c_colon, c_query, c_star, c_term, c_cr;
	logic push, close, err, exec, set_star, set_query, pdig, pdone, kw_bad;
	logic [3:0] kw_now;
	logic q_now;
	logic cmd_bad, exe_bad, qry_bad, clr_esr, set_opc, ese_we, sre_we, psc_we, rep_go;
	logic [7:0] rep_val, stb, esr_set;
	logic [2:0] irq_ev;

	assign c_alpha = (rx_data_i >= 8'h41 && rx_data_i <= 8'h5a)
		|| (rx_data_i >= 8'h61 && rx_data_i <= 8'h7a);
	assign c_digit = rx_data_i >= CH_ZERO && rx_data_i <= 8'h39;
	assign c_space = rx_data_i == CH_SPACE;
	assign c_colon = rx_data_i == CH_COLON;
	assign c_query = rx_data_i == CH_QUERY;
	assign c_star = rx_data_i == CH_STAR;
	assign c_term = rx_data_i == CH_SEMI || rx_data_i == CH_LF;
	assign c_cr = rx_data_i == CH_CR;

	assign tok.ch = rx_data_i;
	assign tok.push = push;
	assign tok.clr = rx_valid_i && !push;

	// Common commands need a star, tree keywords must not have one.
	assign kw_bad = !tok.hit || (star_q != (tok.idx < KW_TREE));
	assign kw_now = close ? tok.idx : kw_q;
	assign q_now = query_q || set_query;

	// Character step of the syntax checker.
	always_comb begin
		state_d = state_q;
		push = 1'b0;
		close = 1'b0;
		err = 1'b0;
		exec = 1'b0;
		set_star = 1'b0;
		set_query = 1'b0;
		pdig = 1'b0;
		pdone = 1'b0;
		if (rx_valid_i) begin
			unique case (state_q)
				ST_IDLE: begin
					if (c_star) begin
						set_star = 1'b1;
						state_d = ST_KEY;
					end else if (c_alpha) begin
						push = 1'b1;
						state_d = ST_KEY;
					end else if (c_colon) begin
						state_d = ST_KEY;
					end else if (!(c_space || c_cr || c_term)) begin
						err = 1'b1;
					end
				end
				ST_KEY: begin
					if (c_alpha) begin
						err = query_q;
						push = !query_q;
					end else if (c_colon) begin
						// An empty keyword here means a colon, star, question mark or carriage return came just before this colon.
						err = star_q || query_q || tok.empty;
						close = !err;
					end else if (c_query) begin
						err = query_q || tok.empty;
						close = !err;
						set_query = !err;
					end else if (c_space || c_term) begin
						err = tok.empty && !query_q;
						close = !tok.empty;
						exec = c_term;
						if (c_space) begin
							state_d = ST_PARAM;
						end
					end else if (!c_cr) begin
						// Digits glued to a keyword lack the separating space.
						err = 1'b1;
					end
				end
				ST_PARAM: begin
					if (c_digit) begin
						err = pdone_q;
						pdig = !pdone_q;
					end else if (c_space) begin
						pdone = has_par_q;
					end else if (c_term) begin
						exec = 1'b1;
					end else if (!c_cr) begin
						// A colon after a space is refused here.
						err = 1'b1;
					end
				end
				ST_SKIP: begin
					if (c_term) begin
						state_d = ST_IDLE;
					end
				end
			endcase
			if (close && kw_bad) begin
				err = 1'b1;
			end
			if (err) begin
				exec = 1'b0;
				state_d = c_term ? ST_IDLE : ST_SKIP;
			end else if (exec) begin
				state_d = ST_IDLE;
			end
		end
	end

	// Command execution at the terminator.
	always_comb begin
		cmd_bad = 1'b0;
		exe_bad = 1'b0;
		qry_bad = 1'b0;
		clr_esr = 1'b0;
		set_opc = 1'b0;
		ese_we = 1'b0;
		sre_we = 1'b0;
		psc_we = 1'b0;
		rep_go = 1'b0;
		rep_val = 8'h00;
		if (exec && star_q) begin
			if (q_now && has_par_q) begin
				cmd_bad = 1'b1;
			end else if (q_now) begin
				rep_go = 1'b1;
				unique case (kw_now)
					KW_ESR: begin
						rep_val = esr_q;
						clr_esr = !rep.busy;
					end
					KW_ESE: rep_val = ese_q;
					KW_SRE: rep_val = sre_q;
					KW_STB: rep_val = stb;
					KW_OPC: rep_val = 8'h01;
					KW_PSC: rep_val = {7'h00, psc_q};
					default: begin
						rep_go = 1'b0;
						cmd_bad = 1'b1;
					end
				endcase
				if (rep_go && rep.busy) begin
					rep_go = 1'b0;
					qry_bad = 1'b1;
				end
			end else begin
				unique case (kw_now)
					KW_CLS: begin
						cmd_bad = has_par_q;
						clr_esr = !has_par_q;
					end
					KW_OPC: begin
						cmd_bad = has_par_q;
						set_opc = !has_par_q;
					end
					KW_ESE, KW_SRE, KW_PSC: begin
						// One decimal weighted sum, at most one byte.
						cmd_bad = !has_par_q;
						exe_bad = has_par_q && over_q;
						ese_we = has_par_q && !over_q && kw_now == KW_ESE;
						sre_we = has_par_q && !over_q && kw_now == KW_SRE;
						psc_we = has_par_q && !over_q && kw_now == KW_PSC;
					end
					default: cmd_bad = 1'b1;
				endcase
			end
		end
	end

	assign rep.start = rep_go;
	assign rep.value = rep_val;

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			state_q <= ST_IDLE;
			star_q <= 1'b0;
			query_q <= 1'b0;
			kw_q <= 4'h0;
		end else begin
			state_q <= state_d;
			if (state_d == ST_IDLE) begin
				star_q <= 1'b0;
				query_q <= 1'b0;
			end else begin
				star_q <= star_q || set_star;
				query_q <= query_q || set_query;
			end
			if (close) begin
				kw_q <= tok.idx;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i || state_d != ST_PARAM) begin
			par_q <= 9'h000;
			has_par_q <= 1'b0;
			pdone_q <= 1'b0;
			over_q <= 1'b0;
		end else if (pdig) begin
			has_par_q <= 1'b1;
			if (over_q || par_q > 9'd25 || (par_q == 9'd25 && rx_data_i > 8'h35)) begin
				over_q <= 1'b1;
			end else begin
				par_q <= 9'(par_q * 9'd10 + 9'(rx_data_i - CH_ZERO));
			end
		end else if (pdone) begin
			pdone_q <= 1'b1;
		end
	end

	assign esr_set = {1'b0, 1'b0, cmd_bad || err, exe_bad, dev_err_i, qry_bad, 1'b0, set_opc};

	// A new event beats a clear in the same cycle.
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			esr_q <= ESR_RST;
		end else begin
			esr_q <= (clr_esr ? 8'h00 : esr_q) | esr_set;
		end
	end

	// Enable registers: only reset and writes change them, never *CLS.
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			ese_q <= ENA_RST;
			sre_q <= ENA_RST;
			psc_q <= PSC_RST;
		end else begin
			if (ese_we) begin
				ese_q <= par_q[7:0];
			end else if (reg_wr_i && reg_addr_i == REG_ESE) begin
				ese_q <= reg_wdata_i;
			end
			if (sre_we) begin
				sre_q <= par_q[7:0] & SRE_MASK;
			end else if (reg_wr_i && reg_addr_i == REG_SRE) begin
				sre_q <= reg_wdata_i & SRE_MASK;
			end
			if (psc_we) begin
				psc_q <= par_q != 9'h000;
			end else if (reg_wr_i && reg_addr_i == REG_PSC) begin
				psc_q <= reg_wdata_i[0];
			end
		end
	end

	// Status byte is live: inputs, buffer state and masked summaries.
	always_comb begin
		stb = 8'h00;
		stb[STB_RAMPDN] = ext_rampdown_i;
		stb[STB_QUENCH] = quench_i;
		stb[STB_MAV] = rep.busy;
		stb[STB_ESB] = |(esr_q & ese_q);
		stb[STB_RQS] = |(stb & sre_q);
	end

	assign irq_ev = {stb[STB_RQS] && !rqs_q, err || cmd_bad || exe_bad || qry_bad,
		exec && !cmd_bad && !exe_bad && !qry_bad};

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			irq_stat_q <= IRQ_RST;
			irq_en_q <= IRQ_RST;
			rqs_q <= 1'b0;
		end else begin
			rqs_q <= stb[STB_RQS];
			if (reg_wr_i && reg_addr_i == REG_IRQ_CLR) begin
				irq_stat_q <= (irq_stat_q & ~reg_wdata_i[2:0]) | irq_ev;
			end else begin
				irq_stat_q <= irq_stat_q | irq_ev;
			end
			if (reg_wr_i && reg_addr_i == REG_IRQ_EN) begin
				irq_en_q <= reg_wdata_i[2:0];
			end
		end
	end

	assign irq_o = |(irq_stat_q & irq_en_q);

	// Port reads never disturb any register.
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				REG_STB: reg_rdata_o <= stb;
				REG_ESR: reg_rdata_o <= esr_q;
				REG_ESE: reg_rdata_o <= ese_q;
				REG_SRE: reg_rdata_o <= sre_q;
				REG_PSC: reg_rdata_o <= {7'h00, psc_q};
				REG_IRQ_STAT: reg_rdata_o <= {5'h00, irq_stat_q};
				REG_IRQ_EN: reg_rdata_o <= {5'h00, irq_en_q};
				default: reg_rdata_o <= 8'h00;
			endcase
		end else begin
			reg_rdata_o <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// [scp_pkg.sv]
// Shared constants and types of the status and command parser.
// Assumes one 200 MHz clock and a byte-wide ASCII command stream from the host.
package scp_pkg;
	// Keyword buffer depth and keyword table size.
	localparam int TOK_MAX = 12;
	localparam int KW_N = 16;

	// Keyword codes: 0 to 6 are common commands reached with a star, the rest form the tree.
	localparam logic [3:0] KW_CLS = 4'h0;
	localparam logic [3:0] KW_ESR = 4'h1;
	localparam logic [3:0] KW_ESE = 4'h2;
	localparam logic [3:0] KW_SRE = 4'h3;
	localparam logic [3:0] KW_STB = 4'h4;
	localparam logic [3:0] KW_OPC = 4'h5;
	localparam logic [3:0] KW_PSC = 4'h6;
	localparam logic [3:0] KW_TREE = 4'h7;

	// Characters the parser reacts to.
	localparam logic [7:0] CH_SPACE = 8'h20;
	localparam logic [7:0] CH_COLON = 8'h3a;
	localparam logic [7:0] CH_QUERY = 8'h3f;
	localparam logic [7:0] CH_STAR = 8'h2a;
	localparam logic [7:0] CH_SEMI = 8'h3b;
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_ZERO = 8'h30;

	// Register port offsets.
	localparam logic [7:0] REG_STB = 8'h00;
	localparam logic [7:0] REG_ESR = 8'h04;
	localparam logic [7:0] REG_ESE = 8'h08;
	localparam logic [7:0] REG_SRE = 8'h0c;
	localparam logic [7:0] REG_PSC = 8'h10;
	localparam logic [7:0] REG_IRQ_STAT = 8'h14;
	localparam logic [7:0] REG_IRQ_CLR = 8'h18;
	localparam logic [7:0] REG_IRQ_EN = 8'h1c;

	// Status byte bit positions.
	localparam int STB_RAMPDN = 1;
	localparam int STB_QUENCH = 2;
	localparam int STB_MAV = 3;
	localparam int STB_ESB = 5;
	localparam int STB_RQS = 6;

	// Standard event bit positions.
	localparam int ESR_OPC = 0;
	localparam int ESR_QYE = 2;
	localparam int ESR_DDE = 3;
	localparam int ESR_EXE = 4;
	localparam int ESR_CME = 5;
	localparam int ESR_PON = 7;

	// Interrupt status bit positions.
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ERR = 1;
	localparam int IRQ_SRQ = 2;

	// Reset values and masks.
	localparam logic [7:0] ESR_RST = 8'h80;
	localparam logic [7:0] ENA_RST = 8'h00;
	localparam logic [7:0] SRE_MASK = 8'hbf;
	localparam logic PSC_RST = 1'b1;
	localparam logic [2:0] IRQ_RST = 3'h0;
	localparam logic [8:0] PAR_MAX = 9'h0ff;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_KEY = 2'b01,
		ST_PARAM = 2'b11,
		ST_SKIP = 2'b10
	} scp_state_t;
endpackage

// [scp_links.sv]
// Interfaces between the parser and its keyword matcher and reply buffer.
// Assumes all three modules share one clock.
`timescale 1ns/1ps
`default_nettype none
interface scp_tok_if;
	logic [7:0] ch;
	logic push;
	logic clr;
	logic hit;
	logic [3:0] idx;
	logic empty;
	modport parser(output ch, output push, output clr, input hit, input idx, input empty);
	modport match(input ch, input push, input clr, output hit, output idx, output empty);
endinterface

interface scp_rep_if;
	logic start;
	logic [7:0] value;
	logic busy;
	modport parser(output start, output value, input busy);
	modport reply(input start, input value, output busy);
endinterface
`default_nettype wire

// [scp_kw_match.sv]
// Keyword buffer and matcher against the short and long spelling of each keyword.
// Assumes the parser pushes letters only and clears the buffer after each keyword.
`timescale 1ns/1ps
`default_nettype none
module scp_kw_match (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	scp_tok_if.match tok
);
	import scp_pkg::*;

	logic [7:0] buf_q [TOK_MAX];
	logic [3:0] len_q;
	logic ovf_q;

	// Each entry is long length, short length, then the long spelling left-justified.
	function automatic logic [103:0] kw_entry(input logic [3:0] k);
		unique case (k)
			4'h0: kw_entry = {4'd3, 4'd3, "CLS", 72'h0};
			4'h1: kw_entry = {4'd3, 4'd3, "ESR", 72'h0};
			4'h2: kw_entry = {4'd3, 4'd3, "ESE", 72'h0};
			4'h3: kw_entry = {4'd3, 4'd3, "SRE", 72'h0};
			4'h4: kw_entry = {4'd3, 4'd3, "STB", 72'h0};
			4'h5: kw_entry = {4'd3, 4'd3, "OPC", 72'h0};
			4'h6: kw_entry = {4'd3, 4'd3, "PSC", 72'h0};
			4'h7: kw_entry = {4'd6, 4'd4, "SYSTEM", 48'h0};
			4'h8: kw_entry = {4'd5, 4'd3, "ERROR", 56'h0};
			4'h9: kw_entry = {4'd9, 4'd4, "CONFIGURE", 24'h0};
			4'ha: kw_entry = {4'd7, 4'd4, "CURRENT", 40'h0};
			4'hb: kw_entry = {4'd7, 4'd4, "VOLTAGE", 40'h0};
			4'hc: kw_entry = {4'd5, 4'd5, "FIELD", 56'h0};
			4'hd: kw_entry = {4'd4, 4'd4, "RAMP", 64'h0};
			4'he: kw_entry = {4'd6, 4'd2, "QUENCH", 48'h0};
			4'hf: kw_entry = {4'd7, 4'd2, "PSWITCH", 40'h0};
		endcase
	endfunction

	// Letters are folded to upper case on entry.
	function automatic logic [7:0] to_upper(input logic [7:0] c);
		to_upper = (c >= 8'h61 && c <= 8'h7a) ? c - 8'h20 : c;
	endfunction

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			len_q <= 4'h0;
			ovf_q <= 1'b0;
		end else if (tok.clr) begin
			len_q <= 4'h0;
			ovf_q <= 1'b0;
		end else if (tok.push) begin
			if (32'(len_q) < TOK_MAX) begin
				len_q <= len_q + 4'h1;
			end else begin
				ovf_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (tok.push && 32'(len_q) < TOK_MAX) begin
			buf_q[len_q] <= to_upper(tok.ch);
		end
	end

	assign tok.empty = (len_q == 4'h0) && !ovf_q;

	// Only the exact short or exact long length with matching letters is a hit.
	always_comb begin
		logic [103:0] e;
		logic same;
		e = '0;
		same = 1'b0;
		tok.hit = 1'b0;
		tok.idx = 4'h0;
		for (int k = 0; k < KW_N; k++) begin
			e = kw_entry(k[3:0]);
			same = 1'b1;
			for (int i = 0; i < TOK_MAX; i++) begin
				if (i < 32'(len_q) && buf_q[i] != e[95 - 8 * i -: 8]) begin
					same = 1'b0;
				end
			end
			if (!ovf_q && same && !tok.hit && (len_q == e[99:96] || len_q == e[103:100])) begin
				tok.hit = 1'b1;
				tok.idx = k[3:0];
			end
		end
	end
endmodule
`default_nettype wire

// [scp_reply.sv]
// Serial output buffer: turns one value into decimal digits and a line feed.
// Assumes the parser starts a reply only while the buffer is empty.
`timescale 1ns/1ps
`default_nettype none
module scp_reply (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	scp_rep_if.reply rep,
	output logic [7:0] tx_data_o,
	output logic tx_valid_o,
	input wire logic tx_ready_i
);
	import scp_pkg::*;

	logic [31:0] sh_q;
	logic [2:0] cnt_q;
	logic [7:0] d_h;
	logic [7:0] d_t;
	logic [7:0] d_u;

	assign d_h = CH_ZERO + rep.value / 8'd100;
	assign d_t = CH_ZERO + (rep.value / 8'd10) % 8'd10;
	assign d_u = CH_ZERO + rep.value % 8'd10;

	// Leading zeros are dropped so the reply is the plain decimal sum.
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			sh_q <= 32'h0;
			cnt_q <= 3'h0;
		end else if (rep.start && cnt_q == 3'h0) begin
			if (d_h != CH_ZERO) begin
				sh_q <= {d_h, d_t, d_u, CH_LF};
				cnt_q <= 3'h4;
			end else if (d_t != CH_ZERO) begin
				sh_q <= {d_t, d_u, CH_LF, 8'h00};
				cnt_q <= 3'h3;
			end else begin
				sh_q <= {d_u, CH_LF, 16'h0};
				cnt_q <= 3'h2;
			end
		end else if (tx_valid_o && tx_ready_i) begin
			sh_q <= {sh_q[23:0], 8'h00};
			cnt_q <= cnt_q - 3'h1;
		end
	end

	assign tx_data_o = sh_q[31:24];
	assign tx_valid_o = cnt_q != 3'h0;
	// Busy drops once the host has taken the last byte.
	assign rep.busy = cnt_q != 3'h0;
endmodule
`default_nettype wire

// [scp_props.sv]
// Port checker of the status and command parser.
// Assumes a bind to scp_status_parser; it sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module scp_props
	import scp_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	input wire logic [7:0] tx_data_o,
	input wire logic tx_valid_o,
	input wire logic tx_ready_i,
	input wire logic ext_rampdown_i,
	input wire logic quench_i,
	input wire logic dev_err_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic irq_o
);
	logic [3:0] rxh_q;
	logic rd_stb, rd_esr;

	assign rd_stb = reg_rd_i && reg_addr_i == REG_STB;
	assign rd_esr = reg_rd_i && reg_addr_i == REG_ESR;

	// History of received bytes, so event reads are judged only on a quiet stream.
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			rxh_q <= 4'h0;
		end else begin
			rxh_q <= {rxh_q[2:0], rx_valid_i};
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);

	a_cond_rampdown: assert property (
		rd_stb && $stable(ext_rampdown_i) |=> reg_rdata_o[STB_RAMPDN] == $past(ext_rampdown_i)
	) else $error("rampdown bit does not follow its input");
	a_cond_quench: assert property (
		rd_stb && $stable(quench_i) |=> reg_rdata_o[STB_QUENCH] == $past(quench_i)
	) else $error("quench bit does not follow its input");
	a_unused_bits_zero: assert property (
		rd_stb |=> reg_rdata_o[0] == 1'b0 && reg_rdata_o[4] == 1'b0 && reg_rdata_o[7] == 1'b0
	) else $error("unused status bit reads one");
	a_reply_holds: assert property (
		tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o)
	) else $error("reply byte dropped before it was taken");
	a_irq_masked: assert property (
		reg_wr_i && reg_addr_i == REG_IRQ_EN && reg_wdata_i == 8'h00 |=> ##1 !irq_o
	) else $error("interrupt high with every enable clear");
	a_ese_readback: assert property (
		reg_rd_i && reg_addr_i == REG_ESE && $past(reg_wr_i) && $past(reg_addr_i) == REG_ESE
		|=> reg_rdata_o == $past(reg_wdata_i, 2)
	) else $error("event enable reads back a different value");
	a_event_sticky: assert property (
		rd_esr && $past(rd_esr, 2) && rxh_q == 4'h0 && !rx_valid_i
		|=> ($past(reg_rdata_o, 2) & ~reg_rdata_o) == 8'h00
	) else $error("event bit cleared without a clearing command");
	a_sre_bit6_zero: assert property (
		reg_rd_i && reg_addr_i == REG_SRE |=> !reg_rdata_o[STB_RQS]
	) else $error("summary enable bit six reads one");

	c_reply_taken: cover property (tx_valid_o && tx_ready_i);
	c_reply_stalled: cover property (tx_valid_o && !tx_ready_i);
	c_irq_rise: cover property ($rose(irq_o));
endmodule
`default_nettype wire

// [scp_host.sv]
// Host computer model: sends command text bytes and rebuilds decimal replies.
// Assumes the parser's clock; stall holds off taking reply bytes.
`timescale 1ns/1ps
`default_nettype none
module scp_host
	import scp_pkg::*;
(
	input wire logic sys_clk_i,
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	output logic tx_ready_o,
	input wire logic [7:0] tx_data_i,
	input wire logic tx_valid_i
);
	logic stall = 1'b0;
	logic [15:0] acc = 16'h0000;
	logic [15:0] val = 16'h0000;
	int nrep = 0;

	initial begin
		rx_valid_o = 1'b0;
		rx_data_o = 8'h00;
		tx_ready_o = 1'b1;
	end

	// A reply is digits closed by a line feed; its value is kept in val.
	always @(posedge sys_clk_i) begin
		tx_ready_o <= !stall;
		if (tx_valid_i && tx_ready_o) begin
			if (tx_data_i == CH_LF) begin
				val <= acc;
				acc <= 16'h0000;
				nrep <= nrep + 1;
			end else begin
				acc <= acc * 16'd10 + {8'h00, tx_data_i - CH_ZERO};
			end
		end
	end

	// Text is sent as given: bare colons, spaces before parameters, one decimal mask.
	task automatic send(input string s);
		for (int i = 0; i < s.len(); i++) begin
			@(posedge sys_clk_i);
			rx_valid_o <= 1'b1;
			rx_data_o <= s[i];
		end
		@(posedge sys_clk_i);
		rx_valid_o <= 1'b0;
		rx_data_o <= ~rx_data_o;
		repeat (2) @(posedge sys_clk_i);
	endtask
endmodule
`default_nettype wire

// [scp_status_parser_tb.sv]
// Self-checking bench of the status and command parser.
// Assumes scp_pkg, the design files, scp_host and scp_props are compiled first.
`timescale 1ns/1ps
`default_nettype none
module scp_status_parser_tb;
	import scp_pkg::*;
	logic sys_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic rx_valid_i, tx_valid_o, tx_ready_i, irq_o;
	logic ext_rampdown_i = 1'b0;
	logic quench_i = 1'b0;
	logic dev_err_i = 1'b0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic [7:0] rx_data_i, tx_data_o, reg_rdata_o;
	int err_total = 0;
	int checks = 0;

	always #2.5 sys_clk_i = ~sys_clk_i;

	scp_status_parser u_dut (.sys_clk_i, .resetn_i, .rx_valid_i, .rx_data_i, .tx_data_o,
		.tx_valid_o, .tx_ready_i, .ext_rampdown_i, .quench_i, .dev_err_i, .reg_addr_i,
		.reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o);
	scp_host u_host (.sys_clk_i(sys_clk_i), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i),
		.tx_ready_o(tx_ready_i), .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o));

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chkrep(input int n, input logic [15:0] exp);
		repeat (300) if (u_host.nrep < n) @(posedge sys_clk_i);
		#1;
		checks++;
		if (u_host.nrep != n || u_host.val !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, u_host.val, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk8(reg_rdata_o, exp);
	endtask

	// A write followed at once by a read of the same register, with no idle cycle between.
	task automatic wrrd(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
		reg_rd_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk8(reg_rdata_o, d);
	endtask

	task automatic chkirq(input logic exp);
		repeat (2) @(posedge sys_clk_i);
		#1;
		chk8({7'h00, irq_o}, {7'h00, exp});
	endtask

	task automatic give_verdict();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk_i);
		err_total++;
		give_verdict();
	end

	initial begin
		repeat (4) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		rd(REG_ESR, ESR_RST);
		rd(REG_ESE, ENA_RST);
		rd(REG_SRE, ENA_RST);
		rd(REG_STB, 8'h00);
		rd(REG_PSC, {7'h00, PSC_RST});
		rd(8'h20, 8'h00);
		u_host.send("*PSC 0\n");
		rd(REG_PSC, 8'h00);
		wrrd(REG_ESE, 8'h5a);
		u_host.send("*ESR?\n");
		chkrep(1, 16'd128);
		rd(REG_ESR, 8'h00);
		u_host.send("*ese   36\n");
		rd(REG_ESE, 8'h24);
		u_host.send("*ESE?\n");
		chkrep(2, 16'd36);
		u_host.send("CONF:CURR\nconfigure:current;");
		rd(REG_ESR, 8'h00);
		u_host.send("CONFI\n");
		rd(REG_ESR, 8'h20);
		rd(REG_STB, 8'h20);
		wr(REG_SRE, 8'h20);
		rd(REG_STB, 8'h60);
		u_host.send("*CLS\n");
		rd(REG_ESE, 8'h24);
		rd(REG_STB, 8'h00);
		u_host.send("CONF :CURR\n");
		rd(REG_ESR, 8'h20);
		u_host.send("*CLS\n");
		repeat (2) begin
			@(posedge sys_clk_i);
			dev_err_i <= 1'b1;
			@(posedge sys_clk_i);
			dev_err_i <= 1'b0;
		end
		u_host.send("*OPC\n");
		rd(REG_ESR, 8'h09);
		rd(REG_ESR, 8'h09);
		u_host.send("*ESR?\n");
		chkrep(3, 16'd9);
		// A mask above one byte is an execution error and leaves the mask alone.
		u_host.send("*SRE 300\n");
		rd(REG_ESR, 8'h10);
		rd(REG_SRE, 8'h20);
		@(posedge sys_clk_i);
		ext_rampdown_i <= 1'b1;
		quench_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		rd(REG_STB, 8'h06);
		wr(REG_STB, 8'hff);
		rd(REG_STB, 8'h06);
		@(posedge sys_clk_i);
		ext_rampdown_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		rd(REG_STB, 8'h04);
		quench_i <= 1'b0;
		u_host.stall <= 1'b1;
		u_host.send("*OPC?\n");
		rd(REG_STB, 8'h08);
		// A query while the reply is still pending is a query error.
		u_host.send("*STB?\n");
		rd(REG_ESR, 8'h14);
		u_host.stall <= 1'b0;
		chkrep(4, 16'd1);
		rd(REG_STB, 8'h60);
		wr(REG_IRQ_CLR, 8'h07);
		wr(REG_IRQ_EN, 8'h02);
		chkirq(1'b0);
		u_host.send("BAD\n");
		chkirq(1'b1);
		rd(REG_IRQ_STAT, 8'h02);
		rd(REG_IRQ_EN, 8'h02);
		wr(REG_IRQ_CLR, 8'h07);
		chkirq(1'b0);
		u_host.send("BAD\n");
		wr(REG_IRQ_EN, 8'h00);
		chkirq(1'b0);
		give_verdict();
	end
endmodule

bind scp_status_parser scp_props u_props (.sys_clk_i, .resetn_i, .rx_valid_i, .rx_data_i,
	.tx_data_o, .tx_valid_o, .tx_ready_i, .ext_rampdown_i, .quench_i, .dev_err_i,
	.reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o);
`default_nettype wire
